/* File: bench/srs_src_model.sv */
// reset pin and watchdog overflow sources facing the sequencer
`timescale 1ns/10ps
module srs_src_model (
   input wire logic i_clk,
   input wire logic i_pin_req,
   input wire logic i_w1_req,
   input wire logic i_w2_req,
   output logic o_reset_pin_n,
   output logic o_wdt_one,
   output logic o_wdt_two
);
   // clean levels only, the analog filter stays outside
   initial {o_reset_pin_n, o_wdt_one, o_wdt_two} = 3'h4;
   always @(posedge i_clk)
   begin
      o_reset_pin_n <= !i_pin_req;
      o_wdt_one <= i_w1_req;
      o_wdt_two <= i_w2_req;
   end
endmodule

/* File: bench/srs_sva.sv */
// timing checks on the reset sequencer ports
`timescale 1ns/10ps
module srs_sva
   import srs_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = 8
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_reset_pin_n,
   input wire logic i_wdt_one_overflow_reset,
   input wire logic i_wdt_two_overflow_reset,
   input wire logic o_osc_en,
   input wire logic o_sys_clk_en,
   input wire logic o_periph_clk_en,
   input wire logic o_wdt2_en,
   input wire logic o_wdt1_clk_en,
   input wire logic o_subclk_en,
   input wire logic o_cpu_run,
   input wire logic o_periph_rst,
   input wire logic o_io_hiz,
   input wire logic o_ram_wr_block,
   input wire logic o_div_load,
   input wire logic [SRS_DIV_W-1:0] o_div_sel
);
   // counts below assume the sim settle length of 8
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   a_pin_stops_osc: assert property (!i_reset_pin_n |=> !o_osc_en && o_io_hiz)
      else $error("pin low did not stop oscillator");
   a_wdt_two_holds: assert property (i_wdt_two_overflow_reset |=>
      !o_sys_clk_en && !o_wdt2_en && o_periph_rst) else $error("wdt two hold wrong");
   a_wdt_one_keeps: assert property (i_wdt_one_overflow_reset && i_reset_pin_n &&
      !i_wdt_two_overflow_reset && o_cpu_run |=> o_osc_en && o_sys_clk_en && !o_periph_clk_en)
      else $error("wdt one hold wrong");
   a_settle_wait: assert property ($rose(o_osc_en) |-> !o_cpu_run [*7])
      else $error("cpu ran before settle");
   // cycles waited with the oscillator on, cpu clocks off and no long-path request
   logic [15:0] settle_seen;
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         settle_seen <= 16'h0000;
      else if (!o_osc_en || o_sys_clk_en || !i_reset_pin_n || i_wdt_two_overflow_reset)
         settle_seen <= 16'h0000;
      else if (settle_seen != 16'hffff)
         settle_seen <= settle_seen + 16'h0001;
   end
   a_settle_ends: assert property (settle_seen <= 16'(SETTLE_CYC + 1))
      else $error("settle wait too long");
   a_div_reload: assert property ($rose(o_periph_rst) |->
      o_div_load && o_div_sel == SRS_DIV_BY8 ##1 !o_div_load) else $error("divider load wrong");
   a_run_state: assert property (o_cpu_run |-> o_sys_clk_en && o_periph_clk_en &&
      o_wdt2_en && !o_periph_rst && !o_io_hiz && !o_ram_wr_block) else $error("run state mixed");
   a_wdt_one_free: assert property (o_periph_rst && o_sys_clk_en && i_reset_pin_n &&
      !i_wdt_one_overflow_reset && !i_wdt_two_overflow_reset |=> o_cpu_run)
      else $error("wdt one release late");
   a_osc_restart: assert property (!o_osc_en && i_reset_pin_n &&
      !i_wdt_two_overflow_reset |=> o_osc_en) else $error("oscillator not restarted");
   a_aux_clocks: assert property (o_subclk_en && o_wdt1_clk_en == o_osc_en)
      else $error("aux clocks wrong");
endmodule
bind srs_system_reset_sequencer srs_sva #(.SETTLE_CYC(SETTLE_CYC)) sva (.*);

/* File: bench/srs_system_reset_sequencer_tb.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
module srs_system_reset_sequencer_tb;
   import srs_pkg::*;
   logic i_clk = 0, i_sys_rst = 1, p = 0, w1 = 0, w2 = 0;
   wire i_reset_pin_n, i_wdt_one_overflow_reset, i_wdt_two_overflow_reset;
   logic o_osc_en, o_sys_clk_en, o_periph_clk_en, o_wdt2_en, o_wdt1_clk_en, o_subclk_en;
   logic o_cpu_run, o_periph_rst, o_io_hiz, o_ram_wr_block, o_div_load;
   logic [SRS_DIV_W-1:0] o_div_sel;
   int failures = 0, total_checks = 0, cyc = 0;
   always #5 i_clk = ~i_clk;
   srs_src_model src (.i_clk(i_clk), .i_pin_req(p), .i_w1_req(w1), .i_w2_req(w2),
      .o_reset_pin_n(i_reset_pin_n), .o_wdt_one(i_wdt_one_overflow_reset),
      .o_wdt_two(i_wdt_two_overflow_reset));
   srs_system_reset_sequencer #(.SETTLE_CYC(8)) dut (.*);
   task chk(string n, logic [15:0] s, logic [15:0] e);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %s exp %h saw %h", n, e, s);
      end
   endtask
   task finish_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // hang guard, runs are under a hundred cycles
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         failures++;
         finish_test();
      end
   end
   // pin or watchdog two reset, then count the settle wait
   task hard_case(logic use_pin);
      int n;
      n = 0;
      @(posedge i_clk) #1 {p, w2} = {use_pin, !use_pin};
      repeat (3) @(posedge i_clk);
      #1 chk("osc", o_osc_en, !use_pin);
      chk("hold", {o_sys_clk_en, o_periph_clk_en, o_wdt2_en, o_cpu_run, o_periph_rst, o_io_hiz,
         o_ram_wr_block}, 7'h07);
      {p, w2} = 0;
      repeat (2) @(posedge i_clk);
      #1 chk("osc on", o_osc_en, 1);
      while (!o_cpu_run)
      begin
         @(posedge i_clk) #1 n++;
      end
      chk("settle", n, 8);
   endtask
   // one-cycle watchdog one pulse keeps oscillator and cpu clock alive, peripheral clock off
   task soft_case();
      @(posedge i_clk) #1 w1 = 1;
      @(posedge i_clk) #1 w1 = 0;
      @(posedge i_clk) #1 chk("soft", {o_osc_en, o_sys_clk_en, o_wdt1_clk_en, o_subclk_en,
         o_periph_clk_en, o_wdt2_en, o_periph_rst, o_io_hiz, o_div_load}, 9'h1e7);
      chk("div", o_div_sel, SRS_DIV_BY8);
      @(posedge i_clk) #1 chk("back", {o_cpu_run, o_periph_clk_en}, 2'h3);
   endtask
   // pin low during a watchdog one hold takes the long path
   task override_case();
      @(posedge i_clk) #1 w1 = 1;
      repeat (3) @(posedge i_clk);
      #1 p = 1;
      repeat (3) @(posedge i_clk);
      #1 chk("override", {o_osc_en, o_sys_clk_en, o_cpu_run, o_io_hiz}, 4'h1);
      {p, w1} = 0;
      repeat (12) @(posedge i_clk);
      #1 chk("rerun", {o_cpu_run, o_osc_en}, 2'h3);
   endtask
   initial
   begin
      repeat (8) @(posedge i_clk);
      #1 i_sys_rst = 0;
      while (!o_cpu_run) @(posedge i_clk) #1;
      hard_case(1);
      hard_case(0);
      soft_case();
      override_case();
      finish_test();
   end
endmodule

/* File: pkg/srs_pkg.sv */
// constants and types for the system reset sequencer
package srs_pkg;
   // stabilization wait defaults to 2^15 prescaled main clock periods
   localparam int unsigned SRS_OSC_SETTLE_EXP = 15;
   localparam int unsigned SRS_OSC_SETTLE_CYC = 32'h0000_8000;
   localparam int SRS_CNT_W = 16;
   // clock divider select encoding, reset value selects fxx/8
   localparam int SRS_DIV_W = 3;
   localparam logic [2:0] SRS_DIV_BY8 = 3'h3;
   localparam logic [15:0] SRS_CNT_ZERO = 16'h0000;
   localparam logic [15:0] SRS_CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {
      SRS_PIN_HOLD,   // pin or second watchdog reset active, oscillator off while the pin is low
      SRS_SETTLE,     // oscillator running, waiting for stabilization
      SRS_WDT1_HOLD,  // first watchdog reset, oscillator and cpu clock kept running
      SRS_RUN
   } srs_state_t;

   typedef struct packed {
      srs_state_t st;
      logic [15:0] cnt;
      logic osc_en;
      logic sys_clk_en;
      logic periph_clk_en;
      logic wdt2_en;
      logic cpu_run;
      logic periph_rst;
      logic io_hiz;
      logic ram_wr_block;
      logic div_load;
   } srs_regs_t;
endpackage

/* File: rtl/srs_system_reset_sequencer.sv */
// reset sequencer combining pin reset and two watchdog overflow resets
`timescale 1ns/10ps
module srs_system_reset_sequencer
   import srs_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = SRS_OSC_SETTLE_CYC
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_reset_pin_n,
   input wire logic i_wdt_one_overflow_reset,
   input wire logic i_wdt_two_overflow_reset,
   output logic o_osc_en,
   output logic o_sys_clk_en,
   output logic o_periph_clk_en,
   output logic o_wdt2_en,
   output logic o_wdt1_clk_en,
   output logic o_subclk_en,
   output logic o_cpu_run,
   output logic o_periph_rst,
   output logic o_io_hiz,
   output logic o_ram_wr_block,
   output logic o_div_load,
   output logic [SRS_DIV_W-1:0] o_div_sel
);

   // long path: pin low or watchdog two, cpu clocks stop, settle wait on release
   // short path: watchdog one alone, oscillator and cpu clock keep running, peripheral clock stops
   // a long-path request always overrides a short hold or a running wait
   // outputs change one cycle after a request is sampled
   // the settle length counts i_clk cycles, taken as the prescaled main clock
   // watchdog one releases on the first sampled edge its request is low
   // a ram write colliding with reset is the ram's business, later ones are gated
   // the subclock is never gated here, this block has no stop mode
   // the divider code is fixed; div_load marks when the divider must take it

   // a zero settle length would wrap to the longest 16-bit wait, so it counts as one
   localparam int unsigned SETTLE_USE = (SETTLE_CYC == 0) ? 1 : SETTLE_CYC;

   srs_regs_t s_r;
   srs_regs_t s_nxt;
   logic [15:0] settle_last;
   logic settle_done;

   // count runs 0..settle-1; parameter narrowed on purpose
   assign settle_last = 16'(SETTLE_USE - 1);
   // last count of the settle wait reached
   assign settle_done = (s_r.cnt == settle_last);

   // pin low or watchdog two: long path with a settle wait on release
   function automatic logic hard_req(input logic pin_n, input logic wdt_two);
      begin
         hard_req = !pin_n || wdt_two;
      end
   endfunction

   // next state of the whole sequencer
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.div_load = 1'b0;
      unique case (s_r.st)
         SRS_PIN_HOLD:
         begin
            // the count stays cleared so every wait starts from zero
            s_nxt.cnt = SRS_CNT_ZERO;
            // oscillator follows the pin, even while watchdog two holds
            s_nxt.osc_en = i_reset_pin_n;
            // oscillator restarts once the pin and watchdog two are gone
            if (!hard_req(i_reset_pin_n, i_wdt_two_overflow_reset))
            begin
               s_nxt.st = SRS_SETTLE;
               s_nxt.osc_en = 1'b1;
            end
         end

         // oscillator running, cpu side still held until the count ends
         SRS_SETTLE:
         begin
            // a new long-path request restarts the wait from zero
            if (hard_req(i_reset_pin_n, i_wdt_two_overflow_reset))
            begin
               s_nxt.st = SRS_PIN_HOLD;
               s_nxt.osc_en = i_reset_pin_n;
            end
            else if (settle_done)
            begin
               // release everything together after the oscillator settled
               // so no unit sees a half-woken chip
               s_nxt.st = SRS_RUN;
               s_nxt.sys_clk_en = 1'b1;
               s_nxt.periph_clk_en = 1'b1;
               s_nxt.wdt2_en = 1'b1;
               s_nxt.cpu_run = 1'b1;
               s_nxt.periph_rst = 1'b0;
               s_nxt.io_hiz = 1'b0;
               s_nxt.ram_wr_block = 1'b0;
            end
            else
            begin
               // never passes settle_last, so 16 bits cover 2^15
               s_nxt.cnt = s_r.cnt + SRS_CNT_ONE;
            end
         end

         // watchdog one hold: oscillator and cpu clock keep running, peripheral clock stopped
         SRS_WDT1_HOLD:
         begin
            // a long-path request overrides the short hold
            if (hard_req(i_reset_pin_n, i_wdt_two_overflow_reset))
            begin
               s_nxt.st = SRS_PIN_HOLD;
               s_nxt.osc_en = i_reset_pin_n;
               s_nxt.sys_clk_en = 1'b0;
            end
            else if (!i_wdt_one_overflow_reset)
            begin
               // no settle wait: oscillator never stopped
               s_nxt.st = SRS_RUN;
               s_nxt.periph_clk_en = 1'b1;
               s_nxt.wdt2_en = 1'b1;
               s_nxt.cpu_run = 1'b1;
               s_nxt.periph_rst = 1'b0;
               s_nxt.io_hiz = 1'b0;
               s_nxt.ram_wr_block = 1'b0;
            end
         end

         SRS_RUN:
         begin
            // pin and watchdog two take priority over watchdog one
            if (hard_req(i_reset_pin_n, i_wdt_two_overflow_reset))
            begin
               // long path entry: cpu side stops, oscillator follows the pin, divider reloads
               s_nxt.st = SRS_PIN_HOLD;
               s_nxt.osc_en = i_reset_pin_n;
               s_nxt.sys_clk_en = 1'b0;
               s_nxt.periph_clk_en = 1'b0;
               s_nxt.wdt2_en = 1'b0;
               s_nxt.cpu_run = 1'b0;
               s_nxt.periph_rst = 1'b1;
               s_nxt.io_hiz = 1'b1;
               s_nxt.ram_wr_block = 1'b1;
               s_nxt.div_load = 1'b1;
            end
            else if (i_wdt_one_overflow_reset)
            begin
               // short path: oscillator and cpu clock keep running, peripheral clock stops
               s_nxt.st = SRS_WDT1_HOLD;
               s_nxt.periph_clk_en = 1'b0;
               s_nxt.wdt2_en = 1'b0;
               s_nxt.cpu_run = 1'b0;
               s_nxt.periph_rst = 1'b1;
               s_nxt.io_hiz = 1'b1;
               s_nxt.ram_wr_block = 1'b1;
               s_nxt.div_load = 1'b1;
            end
         end
      endcase
   end

   // power-on looks like a pin reset; oscillator started on release
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         // only constants here; long path with the oscillator off
         s_r.st <= SRS_PIN_HOLD;
         s_r.cnt <= SRS_CNT_ZERO;
         s_r.osc_en <= 1'b0;
         s_r.sys_clk_en <= 1'b0;
         s_r.periph_clk_en <= 1'b0;
         s_r.wdt2_en <= 1'b0;
         s_r.cpu_run <= 1'b0;
         s_r.periph_rst <= 1'b1;
         s_r.io_hiz <= 1'b1;
         s_r.ram_wr_block <= 1'b1;
         s_r.div_load <= 1'b1;
      end
      else
      begin
         // registered copy of the next state
         s_r <= s_nxt;
      end
   end

   // clock enables straight from the state flops
   assign o_osc_en = s_r.osc_en;
   assign o_sys_clk_en = s_r.sys_clk_en;
   assign o_periph_clk_en = s_r.periph_clk_en;
   assign o_wdt2_en = s_r.wdt2_en;
   // watchdog one clock stops only with the main oscillator
   assign o_wdt1_clk_en = s_r.osc_en;
   assign o_subclk_en = 1'b1;
   // reset side effects seen by the rest of the chip
   assign o_cpu_run = s_r.cpu_run;
   assign o_periph_rst = s_r.periph_rst;
   assign o_io_hiz = s_r.io_hiz;
   // ram gates writes while reset is held so contents survive
   assign o_ram_wr_block = s_r.ram_wr_block;
   // reload pulse and its fixed code, decoded by the divider
   assign o_div_load = s_r.div_load;
   assign o_div_sel = SRS_DIV_BY8;
endmodule
